// [logic/adc_port_pkg.sv]
package adc_port_pkg;
  // ===========================================================
  // Data widths
  localparam int DATA_W      = 12;
  localparam int CHAN_W      = 3;
  localparam int FIFO_W      = DATA_W + CHAN_W;
  localparam int FIFO_DEPTH  = 16;
  // ===========================================================
  // Conversion timing
  localparam int CONV_EDGES  = 13;
  localparam int CNT_W       = 4;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_EDGES);
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  // ===========================================================
  // Bus layout
  localparam int LOW_LSB     = 0;
  localparam int BYTE_W      = 8;
  localparam int NIB_W       = 4;
  localparam int BIT8        = 8;
  localparam int CH_LSB      = 4;
  localparam int CH_MSB      = 6;
  localparam int TEN_ZERO_W  = 2;
  // ===========================================================
  // Reset values
  localparam logic [DATA_W-1:0] DATA_RST = 12'h000;
  localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
  localparam logic [FIFO_W-1:0] WORD_RST = 15'h0000;
  // ===========================================================
  // States
  typedef enum logic [1:0] {CONV_IDLE, CONV_RUN, CONV_DONE} conv_state_t;
endpackage

// [logic/result_fifo.sv]
module result_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0]      count_q, count_d;
  logic             push, pop;

  // ===========================================================
  // Pointers and fill count
  always_comb begin
    push     = inValid && inReady;
    pop      = outValid && outReady;
    wrPtr_d  = push ? AW'(wrPtr_q + 1'b1) : wrPtr_q;
    rdPtr_d  = pop ? AW'(rdPtr_q + 1'b1) : rdPtr_q;
    count_d  = count_q;
    if (push && !pop) begin
      count_d = (AW+1)'(count_q + 1'b1);
    end else if (pop && !push) begin
      count_d = (AW+1)'(count_q - 1'b1);
    end
    inReady  = (count_q != (AW+1)'(DEPTH));
    outValid = (count_q != '0);
    outData  = mem[rdPtr_q];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end
endmodule

// [logic/adc_parallel_port_conv_ctrl.sv]
module adc_parallel_port_conv_ctrl
  import adc_port_pkg::*;
#(
  parameter bit TEN_BIT = 1'b0
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              sample_start_n,
  input  wire logic              conversion_clock,
  input  wire logic              powerDownReq,
  input  wire logic [DATA_W-1:0] convResult,
  input  wire logic [CHAN_W-1:0] convChannel,
  input  wire logic              chipSelect_n,
  input  wire logic              readStrobe_n,
  input  wire logic              storeStrobe_n,
  input  wire logic              wordMode,
  input  wire logic [DATA_W-1:0] dataIn,
  output logic      [DATA_W-1:0] dataOut,
  output logic      [DATA_W-1:0] dataOe,
  output logic                   busy,
  output logic                   holdMode,
  output logic                   poweredUp,
  output logic      [DATA_W-1:0] writeWord,
  output logic                   writeStrobe,
  output logic                   resultValid
);
  // ===========================================================
  // Edge history
  conv_state_t       state_q, state_d;
  logic [CNT_W-1:0]  edges_q, edges_d;
  logic              startPrev_q, clkPrev_q, rdPrev_q, wrPrev_q;
  logic              startFall, startRise, clkRise, rdFall, wrFall;
  logic              busy_q, busy_d, hold_q, hold_d, power_q, power_d;
  logic [DATA_W-1:0] capRes_q, capRes_d;
  logic [CHAN_W-1:0] capCh_q, capCh_d;
  logic              fifoPush, fifoReady, fifoValid, fifoPop;
  logic [FIFO_W-1:0] fifoIn, fifoOut, rdWord_q, rdWord_d;
  logic [DATA_W-1:0] out_q, out_d, oe_q, oe_d, wrWord_q, wrWord_d;
  logic              wrStb_q, wrStb_d, upper_q, upper_d;
  logic              valid_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      startPrev_q <= 1'b1;
      clkPrev_q   <= 1'b0;
      rdPrev_q    <= 1'b1;
      wrPrev_q    <= 1'b1;
    end else begin
      startPrev_q <= sample_start_n;
      clkPrev_q   <= conversion_clock;
      rdPrev_q    <= readStrobe_n || chipSelect_n;
      wrPrev_q    <= storeStrobe_n || chipSelect_n;
    end
  end

  assign startFall = startPrev_q && !sample_start_n;
  assign startRise = !startPrev_q && sample_start_n;
  assign clkRise   = !clkPrev_q && conversion_clock;
  assign rdFall    = rdPrev_q && !(readStrobe_n || chipSelect_n);
  assign wrFall    = wrPrev_q && !(storeStrobe_n || chipSelect_n);

  // ===========================================================
  // Conversion sequencing
  always_comb begin
    state_d  = state_q;
    edges_d  = edges_q;
    busy_d   = busy_q;
    hold_d   = hold_q;
    power_d  = power_q;
    capRes_d = capRes_q;
    capCh_d  = capCh_q;
    fifoPush = 1'b0;
    if (powerDownReq && !busy_q) begin
      power_d = 1'b0;
    end else if (startRise) begin
      power_d = 1'b1;
    end
    case (state_q)
      CONV_IDLE: begin
        if (startFall && power_q && fifoReady) begin
          hold_d  = 1'b1;
          busy_d  = 1'b1;
          edges_d = CNT_ZERO;
          state_d = CONV_RUN;
        end
      end
      CONV_RUN: begin
        if (clkRise) begin
          edges_d = CNT_W'(edges_q + CNT_ONE);
          if (edges_d == CNT_LAST) begin
            hold_d   = 1'b0;
            capRes_d = convResult;
            capCh_d  = convChannel;
            state_d  = CONV_DONE;
          end
        end
      end
      CONV_DONE: begin
        fifoPush = 1'b1;
        busy_d   = 1'b0;
        state_d  = CONV_IDLE;
      end
      default: begin
        state_d = CONV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q  <= CONV_IDLE;
      edges_q  <= CNT_ZERO;
      busy_q   <= 1'b0;
      hold_q   <= 1'b0;
      power_q  <= 1'b1;
      capRes_q <= DATA_RST;
      capCh_q  <= CHAN_RST;
    end else begin
      state_q  <= state_d;
      edges_q  <= edges_d;
      busy_q   <= busy_d;
      hold_q   <= hold_d;
      power_q  <= power_d;
      capRes_q <= capRes_d;
      capCh_q  <= capCh_d;
    end
  end

  // ===========================================================
  // Result buffer
  assign fifoIn = {capCh_q, capRes_q};

  result_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .inValid  (fifoPush),
    .inReady  (fifoReady),
    .inData   (fifoIn),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoOut)
  );

  // ===========================================================
  // Parallel bus
  always_comb begin
    rdWord_d = rdWord_q;
    upper_d  = upper_q;
    out_d    = out_q;
    oe_d     = oe_q;
    wrWord_d = wrWord_q;
    wrStb_d  = 1'b0;
    fifoPop  = 1'b0;
    if (rdFall) begin
      upper_d = !wordMode && dataIn[BIT8];
      // Word pops on word read or low byte read
      if (fifoValid && (wordMode || !dataIn[BIT8])) begin
        rdWord_d = fifoOut;
        fifoPop  = 1'b1;
      end
    end
    if (readStrobe_n || chipSelect_n || !storeStrobe_n) begin
      oe_d  = '0;
      out_d = '0;
    end else begin
      out_d = '0;
      if (wordMode) begin
        out_d = rdWord_d[DATA_W-1:0];
        oe_d  = '1;
      end else if (upper_d) begin
        out_d[NIB_W-1:LOW_LSB] = rdWord_d[DATA_W-1:BYTE_W];
        out_d[CH_MSB:CH_LSB]   = rdWord_d[FIFO_W-1:DATA_W];
        oe_d                   = DATA_W'(8'hFF);
      end else begin
        out_d[BYTE_W-1:LOW_LSB] = rdWord_d[BYTE_W-1:LOW_LSB];
        oe_d                    = DATA_W'(8'hFF);
      end
      // shared pin input in byte mode
      if (!wordMode) begin
        oe_d[BIT8] = 1'b0;
      end
      // six data bits in low byte
      if (TEN_BIT && (wordMode || !upper_d)) begin
        out_d[TEN_ZERO_W-1:LOW_LSB] = '0;
      end
    end
    if (wrFall) begin
      wrStb_d = 1'b1;
      if (wordMode) begin
        wrWord_d = dataIn;
      end else if (dataIn[BIT8]) begin
        wrWord_d[DATA_W-1:BYTE_W] = dataIn[NIB_W-1:LOW_LSB];
      end else begin
        wrWord_d[BYTE_W-1:LOW_LSB] = dataIn[BYTE_W-1:LOW_LSB];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdWord_q <= WORD_RST;
      upper_q  <= 1'b0;
      out_q    <= DATA_RST;
      oe_q     <= DATA_RST;
      wrWord_q <= DATA_RST;
      wrStb_q  <= 1'b0;
      valid_q  <= 1'b0;
    end else begin
      rdWord_q <= rdWord_d;
      upper_q  <= upper_d;
      out_q    <= out_d;
      oe_q     <= oe_d;
      wrWord_q <= wrWord_d;
      wrStb_q  <= wrStb_d;
      valid_q  <= fifoValid;
    end
  end

  assign dataOut     = out_q;
  assign dataOe      = oe_q;
  assign busy        = busy_q;
  assign holdMode    = hold_q;
  assign poweredUp   = power_q;
  assign writeWord   = wrWord_q;
  assign writeStrobe = wrStb_q;
  assign resultValid = valid_q;
endmodule

// [verification/adc_ctrl_asserts.sv]
module adc_ctrl_asserts
  import adc_port_pkg::*;
#(
  parameter bit TEN_BIT = 1'b0
) (
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire logic              sample_start_n,
  input wire logic              conversion_clock,
  input wire logic              chipSelect_n,
  input wire logic              readStrobe_n,
  input wire logic              storeStrobe_n,
  input wire logic              wordMode,
  input wire logic [DATA_W-1:0] dataIn,
  input wire logic [DATA_W-1:0] dataOut,
  input wire logic [DATA_W-1:0] dataOe,
  input wire logic              busy,
  input wire logic              holdMode,
  input wire logic              writeStrobe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ===========================================================
  // Conversion clock rise counter
  logic             ckPrev_q;
  logic [CNT_W-1:0] rises_q;
  logic [CNT_W-1:0] rises_d;
  always_comb begin
    rises_d = busy ? rises_q : CNT_ZERO;
    if (busy && conversion_clock && !ckPrev_q) rises_d = rises_q + CNT_ONE;
  end
  always_ff @(posedge clk_sys) begin
    ckPrev_q <= conversion_clock;
    rises_q  <= rises_d;
  end
  // ===========================================================
  // Properties
  a_oe_needs_read: assert property (dataOe != '0 |-> $past(!chipSelect_n && !readStrobe_n && storeStrobe_n))
    else $error("bus driven outside a read");
  a_ten_low_zero: assert property (TEN_BIT && dataOe[0] && (wordMode || !dataIn[BIT8]) |-> dataOut[1:0] == 2'b00)
    else $error("low lines not zero");
  a_byte_no_upper: assert property (!wordMode |-> dataOe[DATA_W-1:BIT8] == 4'h0)
    else $error("upper lines driven in byte mode");
  a_busy_with_hold: assert property ($rose(busy) |-> holdMode && !$past(sample_start_n))
    else $error("busy rose without start or hold");
  a_hold_then_busy: assert property ($fell(holdMode) |=> $fell(busy))
    else $error("busy did not fall after hold");
  a_thirteen_rises: assert property ($fell(holdMode) |-> rises_q == CNT_LAST)
    else $error("conversion length wrong");
  a_write_pulse: assert property ($fell(chipSelect_n | storeStrobe_n) && readStrobe_n |-> ##[1:2] writeStrobe)
    else $error("write not taken");
  a_read_drive: assert property ($fell(chipSelect_n | readStrobe_n) && storeStrobe_n
    |-> ##[1:2] dataOe == (wordMode ? 12'hfff : 12'h0ff))
    else $error("read lines not driven");
  c_conv_done: cover property ($fell(busy));
  c_byte_read: cover property (!wordMode && dataOe[0]);
  c_write: cover property (writeStrobe);
endmodule

// [verification/host_bus_model.sv]
module host_bus_model
  import adc_port_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic [DATA_W-1:0] dataOut,
  input  wire logic [DATA_W-1:0] dataOe,
  output logic                   chipSelect_n,
  output logic                   readStrobe_n,
  output logic                   storeStrobe_n,
  output logic                   wordMode,
  output logic      [DATA_W-1:0] dataIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] drive = '0;
  initial {chipSelect_n, readStrobe_n, storeStrobe_n, wordMode} = 4'hf;
  // Released host lines show the inverse of their last value, except bit 8 after a byte transfer
  assign dataIn = (dataOe & dataOut) | (~dataOe & drive);
  task automatic xfer(input logic word, input logic upper, input logic wr, input logic [DATA_W-1:0] val,
                      output logic [DATA_W-1:0] got);
    logic [DATA_W-1:0] nxt;
    @(negedge clk_sys);
    nxt = wr ? val : ~drive;
    if (!word) nxt[BIT8] = upper;
    drive = nxt;
    wordMode = word;
    {chipSelect_n, readStrobe_n, storeStrobe_n} = {1'b0, wr, !wr};
    repeat (3) @(negedge clk_sys);
    got = dataIn;
    {chipSelect_n, readStrobe_n, storeStrobe_n} = 3'b111;
    drive = drive ^ (word ? 12'hfff : 12'heff);
    repeat (2) @(negedge clk_sys);
  endtask
endmodule

// [verification/tb_adc_parallel_port_conv_ctrl.sv]
module tb_adc_parallel_port_conv_ctrl
  import adc_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [DATA_W-1:0] res; logic [CHAN_W-1:0] ch; logic word;} row_t;
  logic              clk_sys = 1'b0;
  logic              rst_n, sample_start_n, conversion_clock, powerDownReq;
  logic              chipSelect_n, readStrobe_n, storeStrobe_n, wordMode;
  logic              busy, holdMode, poweredUp, writeStrobe, resultValid;
  logic [CHAN_W-1:0] convChannel;
  logic [DATA_W-1:0] convResult, dataIn, dataOut, dataOe, writeWord, got, lastWr;
  int                failures = 0;
  int                num_checks = 0;
  row_t              rows [4] = '{'{12'habc, 3'h5, 1'b1}, '{12'h123, 3'h7, 1'b0},
                                  '{12'hfff, 3'h0, 1'b0}, '{12'h001, 3'h2, 1'b1}};
  always #12.5 clk_sys = ~clk_sys;
  adc_parallel_port_conv_ctrl #(.TEN_BIT(1'b1)) DUT (.*);
  host_bus_model host (.*);
  always @(posedge clk_sys) if (writeStrobe === 1'b1) lastWr <= writeWord;
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
    num_checks++;
    if (seen !== want) begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic convert(input logic [DATA_W-1:0] res, input logic [CHAN_W-1:0] ch, input logic exp);
    @(negedge clk_sys);
    {convResult, convChannel, sample_start_n} = {res, ch, 1'b0};
    repeat (3) @(negedge clk_sys);
    sample_start_n = 1'b1;
    check(DATA_W'(busy), DATA_W'(exp));
    check(DATA_W'(holdMode), DATA_W'(exp));
    repeat (2 * CONV_EDGES) begin
      repeat (2) @(negedge clk_sys);
      conversion_clock = ~conversion_clock;
    end
    repeat (6) @(negedge clk_sys);
    check(DATA_W'(busy), 12'h000);
  endtask
  // ===========================================================
  // Main sequence
  initial begin
    {rst_n, sample_start_n, conversion_clock, powerDownReq} = 4'h4;
    {convResult, convChannel, lastWr} = '0;
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    check(dataOe, 12'h000);
    check(DATA_W'({busy, poweredUp}), 12'h001);
    $display("reset test done");
    foreach (rows[i]) begin
      convert(rows[i].res, rows[i].ch, 1'b1);
      host.xfer(rows[i].word, 1'b0, 1'b0, '0, got);
      if (rows[i].word) begin
        check(got, {rows[i].res[11:2], 2'b00});
      end else begin
        check({4'h0, got[7:0]}, {4'h0, rows[i].res[7:2], 2'b00});
        host.xfer(1'b0, 1'b1, 1'b0, '0, got);
        check({4'h0, got[7:0]}, {5'h00, rows[i].ch, rows[i].res[11:8]});
      end
    end
    $display("row test done");
    host.xfer(1'b0, 1'b1, 1'b1, 12'h00a, got);
    host.xfer(1'b0, 1'b0, 1'b1, 12'h05c, got);
    check(lastWr, 12'ha5c);
    host.xfer(1'b1, 1'b0, 1'b1, 12'h3c6, got);
    check(lastWr, 12'h3c6);
    $display("write test done");
    for (int i = 0; i < FIFO_DEPTH; i++) convert(DATA_W'(i * 4), CHAN_W'(i), 1'b1);
    convert(12'hfff, 3'h7, 1'b0);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      host.xfer(1'b1, 1'b0, 1'b0, '0, got);
      check(got, DATA_W'(i * 4));
    end
    check(DATA_W'(resultValid), 12'h000);
    host.xfer(1'b1, 1'b0, 1'b0, '0, got);
    check(got, 12'h03c);
    $display("buffer test done");
    powerDownReq = 1'b1;
    repeat (4) @(negedge clk_sys);
    check(DATA_W'(poweredUp), 12'h000);
    powerDownReq = 1'b0;
    convert(12'h100, 3'h1, 1'b0);
    check(DATA_W'(poweredUp), 12'h001);
    convert(12'h2f8, 3'h6, 1'b1);
    host.xfer(1'b1, 1'b0, 1'b0, '0, got);
    check(got, 12'h2f8);
    $display("power test done");
    results();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    results();
  end
endmodule
bind adc_parallel_port_conv_ctrl adc_ctrl_asserts #(.TEN_BIT(TEN_BIT)) u_chk (.*);
